/* rtl/aea_top.sv */
// apparent and active energy accumulation with line cycle windows and status flags
// Behaviour
// RULE_01: positive-only mode adds only positive active power, all negative samples dropped.
// RULE_02: pulse output follows the same positive-only gated active accumulation.
// RULE_03: mode bit 15 enables positive-only mode; clear after reset.
// RULE_04: power direction changes set went-positive or went-negative flags, drive interrupt.
// RULE_05: active samples below the no-load threshold are not accumulated.
// RULE_06: apparent power is current rms times voltage rms.
// RULE_07: apparent power scaled by one plus signed gain over 4096.
// RULE_08: apparent power path has no offset stage of its own.
// RULE_09: apparent power continuously added into a 49-bit accumulator.
// RULE_10: accumulator additions are signed.
// RULE_11: one apparent sample added every four clock cycles.
// RULE_12: accumulator divided by 8-bit divider; zero divides by one.
// RULE_13: upper 24 divided bits form the unsigned apparent energy register.
// RULE_14: read-clear register returns accumulated energy and clears on each read.
// RULE_15: interrupt when energy register passes half full or overflows.
// RULE_16: line apparent accumulation always runs over counted half line cycles.
// RULE_17: half cycle count comes from unsigned 16-bit register.
// RULE_18: line apparent and line active energy share one window.
// RULE_19: window end sets cycle_done and drives interrupt when enabled.
// RULE_20: line apparent energy uses the main apparent sample path.
// RULE_21: cycle_done sits at status bit 2.
// RULE_22: half cycle count register lives at address 0x1C.
// RULE_23: interrupt held low while any enabled status flag remains set.
// RULE_24: accumulator wraps modulo its width and overflow is reported.
module aea_top #(
  parameter int RMS_W = 24,
  parameter int ACT_W = 24,
  parameter int ACT_FULL_SCALE = 8388607,
  parameter int DFC_BIT = 24
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire aea_pkg::aea_reg_req_s reg_req,
  output logic [aea_pkg::OUT_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [RMS_W-1:0] irms,
  input wire logic [RMS_W-1:0] vrms,
  input wire logic [ACT_W-1:0] active_power,
  input wire logic zero_cross,
  output logic pulse_freq_out,
  output logic irq_o,
  output logic irq_oe
);
  localparam int AE_W = aea_pkg::AE_W;
  localparam int OUT_W = aea_pkg::OUT_W;
  localparam int AP_W = RMS_W + 2;
  localparam int SPW = $clog2(aea_pkg::SAMPLE_PERIOD);
  localparam logic [ACT_W-1:0] NOLOAD_THR = ACT_W'(
    (longint'(ACT_FULL_SCALE) * aea_pkg::NOLOAD_MILLIPCT) / aea_pkg::MILLIPCT_FULL);

  if (AP_W >= AE_W || ACT_W >= AE_W || DFC_BIT >= AE_W || ACT_W < 2) begin : g_chk
    $error("aea_top: widths do not fit the accumulator");
  end

  // the pacing counter wraps on its own, so only a power-of-two period fits
  if (aea_pkg::SAMPLE_PERIOD < 2 || (1 << SPW) != aea_pkg::SAMPLE_PERIOD) begin : g_period_chk
    $error("aea_top: sample period must be a power of two");
  end

  // a non-positive full scale would give a meaningless creep threshold
  if (ACT_FULL_SCALE < 1) begin : g_scale_chk
    $error("aea_top: full scale must be positive");
  end

  // register file
  logic [aea_pkg::MODE_W-1:0] mode;
  logic [aea_pkg::GAIN_W-1:0] apparent_gain;
  logic [aea_pkg::DIV_W-1:0] apparent_energy_divider;
  logic [aea_pkg::LINE_W-1:0] half_cycle_count;
  logic [aea_pkg::STAT_W-1:0] irq_enable;
  logic [aea_pkg::STAT_W-1:0] irq_status;
  logic [OUT_W-1:0] apparent_energy_acc;
  logic [OUT_W-1:0] read_clear_base;
  logic [OUT_W-1:0] line_apparent_energy;
  logic [OUT_W-1:0] line_active_energy;

  // datapath state
  logic [SPW-1:0] phase;
  logic tick;
  logic signed [AP_W-1:0] ap_sample;
  logic [AE_W-1:0] ap_ext;
  logic [AE_W-1:0] ap_acc;
  logic [AE_W:0] ap_sum;
  logic [AE_W-1:0] quotient;
  logic div_done;
  logic [AE_W-1:0] act_ext;
  logic [AE_W-1:0] act_add;
  logic [AE_W-1:0] act_acc;
  logic [AE_W-1:0] next_act_acc;
  logic [ACT_W-1:0] act_mag;
  logic act_pos;
  logic act_loaded;
  logic act_keep;
  logic last_pos;
  logic dir_seen;
  logic [AE_W-1:0] line_ap_sum;
  logic [AE_W-1:0] line_act_sum;
  logic [aea_pkg::LINE_W-1:0] zc_cnt;
  logic [aea_pkg::LINE_W-1:0] zc_target;
  logic window_end;
  logic [OUT_W-1:0] next_vae;

  // events and register strobes
  logic [aea_pkg::STAT_W-1:0] set_vec;
  logic [aea_pkg::STAT_W-1:0] clr_vec;
  logic [aea_pkg::STAT_W-1:0] next_status;
  logic wr_hit;
  logic rd_hit;
  logic rd_read_clear;
  logic rd_status_clear;

  assign wr_hit = reg_req.wr;
  assign rd_hit = reg_req.rd;
  assign rd_read_clear = rd_hit && (reg_req.addr == aea_pkg::ADDR_AE_READ_CLEAR);
  assign rd_status_clear = rd_hit && (reg_req.addr == aea_pkg::ADDR_IRQ_STATUS_CLEAR);

  // sample pacing: one accumulation step per four clocks
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1; // see RULE_11
    end
  end
  assign tick = (phase == SPW'(aea_pkg::SAMPLE_PERIOD - 1));

  aea_apparent #(
    .RMS_W(RMS_W)
  ) u_apparent (
    .core_clk(core_clk),
    .rstn(rstn),
    .irms(irms),
    .vrms(vrms),
    .gain(apparent_gain),
    .ap_sample(ap_sample)
  );

  // apparent energy accumulator, signed add that wraps
  always_comb begin
    ap_ext = {{(AE_W - AP_W){ap_sample[AP_W-1]}}, ap_sample}; // see RULE_10
    ap_sum = {1'b0, ap_acc} + {1'b0, ap_ext};
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ap_acc <= '0;
    end else if (tick) begin
      ap_acc <= ap_sum[AE_W-1:0]; // see RULE_09 see RULE_24
    end
  end

  // the quotient lags the accumulator by one divider pass (about fifty clocks)
  aea_divider #(
    .N(AE_W),
    .D(aea_pkg::DIV_W)
  ) u_divider (
    .core_clk(core_clk),
    .rstn(rstn),
    .dividend(ap_acc),
    .divisor(apparent_energy_divider),
    .quotient(quotient),
    .done(div_done)
  );

  assign next_vae = quotient[AE_W-1 -: OUT_W]; // see RULE_13

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      apparent_energy_acc <= '0;
    end else if (div_done) begin
      apparent_energy_acc <= next_vae;
    end
  end

  // read-clear view is the distance from a base taken at each read
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      read_clear_base <= '0;
    end else if (rd_read_clear) begin
      read_clear_base <= apparent_energy_acc; // see RULE_14
    end
  end

  // active path: creep threshold and positive-only gating
  always_comb begin
    act_ext = {{(AE_W - ACT_W){active_power[ACT_W-1]}}, active_power};
    act_pos = !active_power[ACT_W-1];
    act_mag = act_pos ? active_power : ACT_W'(-active_power);
    act_loaded = (act_mag > NOLOAD_THR); // see RULE_05
    act_keep = act_loaded && (act_pos || !mode[aea_pkg::MODE_POS_ONLY_BIT]); // see RULE_01
    act_add = act_keep ? act_ext : '0;
    next_act_acc = act_acc + act_add;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      act_acc <= '0;
    end else if (tick) begin
      act_acc <= next_act_acc;
    end
  end

  // one pulse per step of the pulse bit of the gated active accumulator
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pulse_freq_out <= 1'b0;
    end else begin
      pulse_freq_out <= tick && (next_act_acc[DFC_BIT] != act_acc[DFC_BIT]); // see RULE_02
    end
  end

  // direction tracking ignores samples inside the creep band so noise cannot flap it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      last_pos <= 1'b1;
      dir_seen <= 1'b0;
    end else if (tick && act_loaded) begin
      last_pos <= act_pos;
      dir_seen <= 1'b1;
    end
  end

  // line window: counts zero crossings, zero count acts as one half cycle
  assign zc_target = (half_cycle_count == '0) ? aea_pkg::LINE_W'(1) : half_cycle_count;
  assign window_end = zero_cross && (zc_cnt + 1'b1 >= zc_target); // see RULE_17

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zc_cnt <= '0;
    end else if (window_end) begin
      zc_cnt <= '0; // see RULE_16
    end else if (zero_cross) begin
      zc_cnt <= zc_cnt + 1'b1;
    end
  end

  // both line sums restart on the same edge so their windows match
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      line_ap_sum <= '0;
      line_act_sum <= '0;
      line_apparent_energy <= '0;
      line_active_energy <= '0;
    end else if (window_end) begin
      line_apparent_energy <= line_ap_sum[AE_W-1 -: OUT_W]; // see RULE_20
      line_active_energy <= line_act_sum[AE_W-1 -: OUT_W]; // see RULE_18
      line_ap_sum <= tick ? ap_ext : '0;
      line_act_sum <= tick ? act_add : '0;
    end else if (tick) begin
      line_ap_sum <= line_ap_sum + ap_ext; // see RULE_20
      line_act_sum <= line_act_sum + act_add;
    end
  end

  // status events
  always_comb begin
    set_vec = '0;
    set_vec[aea_pkg::ST_POWER_WENT_POSITIVE] = tick && act_loaded && dir_seen
      && act_pos && !last_pos; // see RULE_04
    set_vec[aea_pkg::ST_POWER_WENT_NEGATIVE] = tick && act_loaded && dir_seen
      && !act_pos && last_pos; // see RULE_04
    set_vec[aea_pkg::ST_CYCLE_DONE] = window_end; // see RULE_19 see RULE_21
    set_vec[aea_pkg::ST_AE_HALF_FULL] = div_done && !apparent_energy_acc[OUT_W-1]
      && next_vae[OUT_W-1]; // see RULE_15
    set_vec[aea_pkg::ST_AE_OVERFLOW] = tick && !ap_sample[AP_W-1]
      && ap_sum[AE_W]; // see RULE_15 see RULE_24
    clr_vec = rd_status_clear ? irq_status : '0;
    // a flag raised in the clearing cycle survives
    next_status = (irq_status & ~clr_vec) | set_vec;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_status <= aea_pkg::STAT_RESET;
    end else begin
      irq_status <= next_status;
    end
  end

  // open-drain interrupt: pin is only ever pulled low
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_o <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_o <= 1'b0;
      irq_oe <= |(irq_status & irq_enable); // see RULE_23
    end
  end

  // register writes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode <= aea_pkg::MODE_RESET; // see RULE_03
      apparent_gain <= aea_pkg::GAIN_RESET;
      apparent_energy_divider <= aea_pkg::DIVIDER_RESET;
      half_cycle_count <= aea_pkg::HALF_CYCLE_RESET;
      irq_enable <= aea_pkg::STAT_RESET;
    end else if (wr_hit) begin
      case (reg_req.addr)
        aea_pkg::ADDR_MODE: mode <= reg_req.wdata[aea_pkg::MODE_W-1:0]; // see RULE_03
        aea_pkg::ADDR_APPARENT_GAIN: apparent_gain <= reg_req.wdata[aea_pkg::GAIN_W-1:0];
        aea_pkg::ADDR_AE_DIVIDER: begin
          apparent_energy_divider <= reg_req.wdata[aea_pkg::DIV_W-1:0];
        end
        aea_pkg::ADDR_HALF_CYCLE_COUNT: begin
          half_cycle_count <= reg_req.wdata[aea_pkg::LINE_W-1:0]; // see RULE_22
        end
        aea_pkg::ADDR_IRQ_ENABLE: irq_enable <= reg_req.wdata[aea_pkg::STAT_W-1:0];
        default: irq_enable <= irq_enable;
      endcase
    end
  end

  // register reads, answered one clock after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_hit;
      if (rd_hit) begin
        case (reg_req.addr)
          aea_pkg::ADDR_MODE: reg_rdata <= OUT_W'(mode);
          aea_pkg::ADDR_APPARENT_GAIN: reg_rdata <= OUT_W'(apparent_gain);
          aea_pkg::ADDR_AE_DIVIDER: reg_rdata <= OUT_W'(apparent_energy_divider);
          aea_pkg::ADDR_HALF_CYCLE_COUNT: reg_rdata <= OUT_W'(half_cycle_count);
          aea_pkg::ADDR_IRQ_ENABLE: reg_rdata <= OUT_W'(irq_enable);
          aea_pkg::ADDR_IRQ_STATUS: reg_rdata <= OUT_W'(irq_status);
          aea_pkg::ADDR_IRQ_STATUS_CLEAR: reg_rdata <= OUT_W'(irq_status);
          aea_pkg::ADDR_AE_ACC: reg_rdata <= apparent_energy_acc; // see RULE_13
          aea_pkg::ADDR_AE_READ_CLEAR: begin
            reg_rdata <= apparent_energy_acc - read_clear_base; // see RULE_14
          end
          aea_pkg::ADDR_LINE_APPARENT: reg_rdata <= line_apparent_energy;
          aea_pkg::ADDR_LINE_ACTIVE: reg_rdata <= line_active_energy;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule : aea_top

/* shared/aea_pkg.sv */
// shared constants, register map and carrier types of the apparent energy accumulator
package aea_pkg;
  localparam int AE_W = 49;
  localparam int OUT_W = 24;
  localparam int GAIN_W = 12;
  localparam int GAIN_SHIFT = 12;
  localparam int DIV_W = 8;
  localparam int LINE_W = 16;
  localparam int MODE_W = 16;
  localparam int ADDR_W = 6;
  localparam int STAT_W = 5;
  localparam int SAMPLE_PERIOD = 4;
  localparam int NOLOAD_MILLIPCT = 1;
  localparam int MILLIPCT_FULL = 100000;
  localparam int MODE_POS_ONLY_BIT = 15;

  localparam logic [ADDR_W-1:0] ADDR_APPARENT_GAIN = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_AE_ACC = 6'h11;
  localparam logic [ADDR_W-1:0] ADDR_AE_READ_CLEAR = 6'h12;
  localparam logic [ADDR_W-1:0] ADDR_AE_DIVIDER = 6'h13;
  localparam logic [ADDR_W-1:0] ADDR_LINE_APPARENT = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_LINE_ACTIVE = 6'h15;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 6'h17;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS_CLEAR = 6'h19;
  localparam logic [ADDR_W-1:0] ADDR_HALF_CYCLE_COUNT = 6'h1c;

  localparam int ST_POWER_WENT_POSITIVE = 0;
  localparam int ST_POWER_WENT_NEGATIVE = 1;
  localparam int ST_CYCLE_DONE = 2;
  localparam int ST_AE_HALF_FULL = 3;
  localparam int ST_AE_OVERFLOW = 4;

  localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h000;
  localparam logic [DIV_W-1:0] DIVIDER_RESET = 8'h00;
  localparam logic [LINE_W-1:0] HALF_CYCLE_RESET = 16'hffff;
  localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [OUT_W-1:0] wdata;
  } aea_reg_req_s;
endpackage : aea_pkg

/* rtl/aea_apparent.sv */
// apparent power: rms product scaled by the signed gain word
module aea_apparent #(
  parameter int RMS_W = 24
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [RMS_W-1:0] irms,
  input wire logic [RMS_W-1:0] vrms,
  input wire logic [aea_pkg::GAIN_W-1:0] gain,
  output logic signed [RMS_W+1:0] ap_sample
);
  localparam int PW = 2 * RMS_W;
  localparam int SW = RMS_W + 2 + aea_pkg::GAIN_W;

  if (RMS_W < 8 || RMS_W > 32) begin : g_chk
    $error("aea_apparent: RMS_W out of range");
  end

  logic [PW-1:0] product;
  logic signed [RMS_W+1:0] base;
  logic signed [SW-1:0] trim;
  logic signed [RMS_W+1:0] next_ap;

  // no offset stage here: offsets are trimmed in the rms blocks upstream
  always_comb begin
    product = irms * vrms; // see RULE_06
    base = signed'({2'b00, product[PW-1 -: RMS_W]});
    trim = (SW'(base) * SW'(signed'(gain))) >>> aea_pkg::GAIN_SHIFT; // see RULE_07
    next_ap = base + trim[RMS_W+1:0]; // see RULE_08
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ap_sample <= '0;
    end else begin
      ap_sample <= next_ap;
    end
  end
endmodule : aea_apparent

/* rtl/aea_divider.sv */
// serial restoring divider, recomputes the quotient continuously
module aea_divider #(
  parameter int N = 49,
  parameter int D = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [N-1:0] dividend,
  input wire logic [D-1:0] divisor,
  output logic [N-1:0] quotient,
  output logic done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } aea_div_state_e;

  if (N < 2 || D < 1) begin : g_chk
    $error("aea_divider: bad widths");
  end

  aea_div_state_e state;
  logic [N-1:0] num;
  logic [N-1:0] quo;
  logic [D-1:0] den;
  logic [D:0] rem;
  logic [$clog2(N+1)-1:0] cnt;
  logic [D+1:0] trial;

  always_comb begin
    trial = {rem, num[N-1]} - {2'b00, den};
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      num <= '0;
      quo <= '0;
      den <= '0;
      rem <= '0;
      cnt <= '0;
      quotient <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          num <= dividend;
          den <= (divisor == '0) ? D'(1) : divisor; // see RULE_12
          rem <= '0;
          cnt <= '0;
          state <= ST_RUN;
        end
        ST_RUN: begin
          num <= {num[N-2:0], 1'b0};
          if (!trial[D+1]) begin
            rem <= trial[D:0];
            quo <= {quo[N-2:0], 1'b1};
          end else begin
            rem <= {rem[D-1:0], num[N-1]};
            quo <= {quo[N-2:0], 1'b0};
          end
          if (cnt == ($clog2(N+1))'(N - 1)) begin
            quotient <= {quo[N-2:0], ~trial[D+1]};
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : aea_divider

/* testbench/aea_top_chk.sv */
// concurrent checks on the ports of the apparent energy accumulator top
module aea_top_chk #(
  parameter int ACT_W = 24
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire aea_pkg::aea_reg_req_s reg_req,
  input wire logic [aea_pkg::OUT_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [ACT_W-1:0] active_power,
  input wire logic pulse_freq_out,
  input wire logic irq_o,
  input wire logic irq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hcc_sh;
  logic [15:0] mode_sh;
  logic [4:0] en_sh;

  // shadows follow host writes so readback can be judged without the body
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hcc_sh <= aea_pkg::HALF_CYCLE_RESET;
    end else if (reg_req.wr && reg_req.addr == aea_pkg::ADDR_HALF_CYCLE_COUNT) begin
      hcc_sh <= reg_req.wdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) mode_sh <= aea_pkg::MODE_RESET;
    else if (reg_req.wr && reg_req.addr == aea_pkg::ADDR_MODE) mode_sh <= reg_req.wdata[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) en_sh <= '0;
    else if (reg_req.wr && reg_req.addr == aea_pkg::ADDR_IRQ_ENABLE) en_sh <= reg_req.wdata[4:0];
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // no power, or only negative power while positive-only is on
  sequence s_quiet;
    (active_power == '0 || (mode_sh[15] && active_power[ACT_W-1]))[*8];
  endsequence
  sequence s_no_enable;
    (en_sh == '0)[*3];
  endsequence

  a_rvalid_after_rd: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered one cycle later");
  a_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("read answer without a read");
  a_hcc_readback: assert property ((reg_req.rd && reg_req.addr == aea_pkg::ADDR_HALF_CYCLE_COUNT)
    |=> reg_rdata == {8'h00, $past(hcc_sh)})
    else $error("half cycle count readback wrong");
  a_mode_readback: assert property ((reg_req.rd && reg_req.addr == aea_pkg::ADDR_MODE)
    |=> reg_rdata == {8'h00, $past(mode_sh)})
    else $error("mode readback wrong");
  a_no_creep_pulse: assert property (s_quiet |-> !pulse_freq_out)
    else $error("pulse without accumulated power");
  a_pulse_spacing: assert property (pulse_freq_out |=> (!pulse_freq_out)[*3])
    else $error("pulses closer than one sample period");
  // the pin lags the enable register by one clock, so judge the enable one cycle back
  a_irq_needs_enable: assert property ($rose(irq_oe) |-> $past(en_sh) != '0)
    else $error("interrupt raised with nothing enabled");
  a_irq_release: assert property (s_no_enable |-> !irq_oe)
    else $error("interrupt held with nothing enabled");
  a_pin_level: assert property (!irq_o)
    else $error("interrupt pin driven high");
  a_reset_quiet: assert property ($past(!rstn) |-> !irq_oe && !reg_rvalid)
    else $error("outputs active right after reset");
endmodule : aea_top_chk

bind aea_top aea_top_chk #(.ACT_W(ACT_W)) u_chk (
  .core_clk(core_clk),
  .rstn(rstn),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .active_power(active_power),
  .pulse_freq_out(pulse_freq_out),
  .irq_o(irq_o),
  .irq_oe(irq_oe)
);

/* testbench/testbench.sv */
// self-checking bench for the apparent energy accumulator top
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  aea_pkg::aea_reg_req_s reg_req = '0;
  logic [23:0] reg_rdata;
  logic reg_rvalid;
  logic [23:0] irms = '0;
  logic [23:0] vrms = '0;
  logic [23:0] active_power = '0;
  logic zero_cross = 1'b0;
  logic pulse_freq_out;
  logic irq_o;
  logic irq_oe;
  int err_total = 0;
  int total_checks = 0;
  int pulses = 0;
  logic [23:0] rd_val;
  // full-scale rms product keeps its upper 24 bits
  longint ap_full = 64'h0000_0000_00ff_fffe;
  logic [5:0] rst_a [7] = '{6'h16, 6'h10, 6'h13, 6'h1c, 6'h17, 6'h18, 6'h11};
  logic [23:0] rst_v [7] = '{24'h0, 24'h0, 24'h0, 24'h00ffff, 24'h0, 24'h0, 24'h0};
  logic [5:0] rw_a [4] = '{6'h10, 6'h13, 6'h1c, 6'h16};
  logic [23:0] rw_v [4] = '{24'h000800, 24'h0000ff, 24'h00fffe, 24'h008000};

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (pulse_freq_out === 1'b1) pulses++;

  aea_top dut_u (
    .core_clk(core_clk),
    .rstn(rstn),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .irms(irms),
    .vrms(vrms),
    .active_power(active_power),
    .zero_cross(zero_cross),
    .pulse_freq_out(pulse_freq_out),
    .irq_o(irq_o),
    .irq_oe(irq_oe)
  );

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic reg_write(input logic [5:0] a, input logic [23:0] d);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    tick(1);
    reg_req.wr = 1'b0;
    tick(1);
  endtask : reg_write

  task automatic reg_read(input logic [5:0] a, output logic [23:0] d);
    int n;
    n = 0;
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    tick(1);
    reg_req.rd = 1'b0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) check("read answer", 24'h0, 24'h1);
    d = reg_rdata;
    tick(1);
  endtask : reg_read

  task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp, input string what);
    logic [23:0] v;
    reg_read(a, v);
    check(what, v, exp);
  endtask : rd_chk

  // about 100 samples of full-scale power: allow one sample either way
  task automatic rd_range(input logic [5:0] a, input longint k, input string what);
    logic [23:0] v;
    longint lo;
    longint hi;
    lo = (99 * ap_full / k) >> 25;
    hi = (101 * ap_full / k) >> 25;
    reg_read(a, v);
    check(what, 24'(v >= lo && v <= hi), 24'h1);
  endtask : rd_range

  task automatic zc_pulse();
    zero_cross = 1'b1;
    tick(1);
    zero_cross = 1'b0;
    tick(1);
  endtask : zc_pulse

  task automatic full_power(input int n);
    irms = 24'hffffff;
    vrms = 24'hffffff;
    tick(n);
    irms = '0;
    vrms = '0;
  endtask : full_power

  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end

  initial begin
    tick(4);
    rstn = 1'b1;
    tick(1);
    for (int i = 0; i < 7; i++) rd_chk(rst_a[i], rst_v[i], "reset value");
    for (int i = 0; i < 4; i++) begin
      reg_write(rw_a[i], rw_v[i]);
      rd_chk(rw_a[i], rw_v[i], "readback");
    end
    reg_write(6'h10, 24'h0);
    reg_write(6'h13, 24'h0);
    reg_write(6'h16, 24'h0);
    rd_chk(6'h3f, 24'h0, "unmapped read");
    reg_write(6'h11, 24'h000055);
    rd_chk(6'h11, 24'h0, "read-only energy");
    full_power(400);
    tick(200);
    rd_range(6'h11, 1, "energy divide by one");
    rd_range(6'h12, 1, "read clear value");
    rd_chk(6'h12, 24'h0, "read clear after read");
    reg_write(6'h13, 24'h000002);
    tick(200);
    rd_range(6'h11, 2, "energy divide by two");
    reg_write(6'h13, 24'h0);
    reg_read(6'h19, rd_val);
    // a first loaded sample sets no direction flag
    active_power = 24'h100000;
    pulses = 0;
    tick(200);
    check("pulses on load", 24'(pulses > 0), 24'h1);
    active_power = 24'hf00000;
    tick(40);
    reg_read(6'h19, rd_val);
    check("went negative", {22'h0, rd_val[1:0]}, 24'h2);
    active_power = 24'h000032;
    tick(40);
    reg_read(6'h19, rd_val);
    check("creep no flag", {22'h0, rd_val[1:0]}, 24'h0);
    active_power = 24'h100000;
    tick(40);
    reg_read(6'h19, rd_val);
    check("went positive", {22'h0, rd_val[1:0]}, 24'h1);
    reg_write(6'h16, 24'h008000);
    active_power = 24'hf00000;
    tick(20);
    pulses = 0;
    tick(300);
    check("positive only pulses", 24'(pulses), 24'h0);
    reg_write(6'h16, 24'h0);
    active_power = '0;
    reg_write(6'h1c, 24'h000002);
    reg_write(6'h17, 24'h000004);
    reg_read(6'h19, rd_val);
    zc_pulse();
    tick(6);
    check("irq mid window", 24'(irq_oe), 24'h0);
    zc_pulse();
    tick(4);
    check("irq window end", 24'(irq_oe), 24'h1);
    reg_read(6'h18, rd_val);
    check("cycle done bit", 24'(rd_val[2]), 24'h1);
    reg_read(6'h19, rd_val);
    tick(4);
    check("irq released", 24'(irq_oe), 24'h0);
    zc_pulse();
    // a hundred active samples of 2^20 inside the same window as the apparent ones
    active_power = 24'h100000;
    full_power(400);
    active_power = '0;
    tick(10);
    zc_pulse();
    tick(6);
    rd_range(6'h14, 1, "line apparent");
    check("irq second window", 24'(irq_oe), 24'h1);
    rd_chk(6'h15, 24'h000003, "line active");
    reg_write(6'h10, 24'h0007ff);
    tick(200);
    reg_read(6'h12, rd_val);
    full_power(400);
    tick(200);
    // largest positive gain: each sample grows by 2047/4096 of itself
    ap_full = ap_full + ap_full * 2047 / 4096;
    rd_range(6'h12, 1, "gain scaled energy");
    report_and_stop();
  end
endmodule : testbench
